// *** cim_consts.svh ***
// Behaviour
// - unmasked source drives irq output in the way its group mode selects
// - masked source has no effect at all on the irq output
// - clip indicator pin shows live overflow state, whatever the gates hold
// - flags register at index 18h, 8 bits, resets to 00h, writes ignored
// - flag bits 7..0: dac b l/r, dac a l/r, port b/a clock, pos/neg clip
// - a flag reads 1 if its event happened since the previous flags read
// - flag sets on the arrival edge, clears on read, ignores ongoing level
// - reading the flags register clears a pending interrupt
// - each dac channel mute entry, from its detector, sets its own flag
// - each port clock fault indication, from its detector, sets its flag
// - four 2-bit mode fields: port b, port a, mute group, clip group
// - mode 00 on arrival, 01 on removal, 10 while present, 11 reserved
// - gates register at index 17h, same bit order as flags, 1 = masked
`ifndef CIM_CONSTS_SVH
`define CIM_CONSTS_SVH

// ---------------------------------------------------------------
// register indices, byte address is four times the index
// ---------------------------------------------------------------
`define CIM_MODE_IDX 8'h16
`define CIM_GATE_IDX 8'h17
`define CIM_FLAG_IDX 8'h18

// ---------------------------------------------------------------
// reset values and field positions
// ---------------------------------------------------------------
`define CIM_MODE_RST 8'h00
`define CIM_GATE_RST 8'hff
`define CIM_FLAG_RST 8'h00
`define CIM_CLIP_MODE_LSB 0
`define CIM_MUTE_MODE_LSB 2
`define CIM_PORTA_MODE_LSB 4
`define CIM_PORTB_MODE_LSB 6
`define CIM_POS_CLIP_BIT 1
`define CIM_NEG_CLIP_BIT 0

// ---------------------------------------------------------------
// bus answers
// ---------------------------------------------------------------
`define CIM_RESP_OKAY 2'b00
`define CIM_RESP_SLVERR 2'b10

`endif

// *** cim_irq_ctrl.sv ***
`timescale 1ns/100ps
`include "cim_consts.svh"

module cim_irq_ctrl (
  input wire logic aclk, // 40 MHz control clock
  input wire logic aresetn, // synchronous, active low
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire cim_pkg::cim_src_t src_cond, // detector levels, async
  output logic irq, // interrupt, active high
  output logic clip_indicator_pin // live adc overflow state
);
  import cim_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_mapped(input logic [31:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    is_mapped = (a[31:10] == 22'h0) && (a[1:0] == 2'h0) &&
                ((idx == `CIM_MODE_IDX) || (idx == `CIM_GATE_IDX) ||
                 (idx == `CIM_FLAG_IDX));
  endfunction

  // group mode field that governs source bit i
  function automatic cim_mode_t src_mode(input int i, input logic [7:0] m);
    logic [1:0] f;
    f = 2'h0;
    case (i)
      7, 6, 5, 4: f = m[`CIM_MUTE_MODE_LSB +: 2];
      3: f = m[`CIM_PORTB_MODE_LSB +: 2];
      2: f = m[`CIM_PORTA_MODE_LSB +: 2];
      default: f = m[`CIM_CLIP_MODE_LSB +: 2];
    endcase
    src_mode = cim_mode_t'(f);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cim_state_t st_r;
  cim_state_t st_nxt;
  logic [7:0] cond_v;
  logic [7:0] rise;
  logic [7:0] fall;
  logic ar_go;
  logic rd_flags;
  logic wr_go;

  assign cond_v = src_cond;
  // detectors are on serial clocks, so only sync2/prev are examined
  assign rise = st_r.sync2 & ~st_r.prev;
  assign fall = ~st_r.sync2 & st_r.prev;
  assign ar_go = s_axi_arvalid && st_r.arready;
  assign rd_flags = ar_go && is_mapped(s_axi_araddr) &&
                    (s_axi_araddr[9:2] == `CIM_FLAG_IDX);
  assign wr_go = st_r.aw_have && st_r.w_have && !st_r.bvalid;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] lvl;
    logic [7:0] set;
    cim_mode_t md;
    lvl = 8'h0;
    set = 8'h0;
    md = CIM_RISE;
    st_nxt = st_r;

    st_nxt.sync1 = cond_v;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;

    // set beats clear so an edge during the read is not lost
    st_nxt.flags = (rd_flags ? 8'h0 : st_r.flags) | rise;

    for (int i = 0; i < 8; i++) begin
      md = src_mode(i, st_r.modes);
      case (md)
        CIM_RISE: set[i] = rise[i];
        CIM_FALL: set[i] = fall[i];
        CIM_LEVEL: lvl[i] = st_r.sync2[i];
        default: set[i] = 1'b0; // reserved code never fires
      endcase
    end
    // masked edges are not even remembered, so unmasking later is quiet
    set = set & ~st_r.gates;
    st_nxt.pend = (rd_flags ? 8'h0 : st_r.pend) | set;
    st_nxt.irq = |((st_nxt.pend | lvl) & ~st_r.gates);

    // pin ignores the gates entirely
    st_nxt.clip = st_r.sync2[`CIM_POS_CLIP_BIT] |
                  st_r.sync2[`CIM_NEG_CLIP_BIT];

    // write channel: address and data taken in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_idx = s_axi_awaddr[9:2];
      st_nxt.aw_ok = is_mapped(s_axi_awaddr);
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = s_axi_wdata[7:0];
      st_nxt.w_en = s_axi_wstrb[0];
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = st_r.aw_ok ? `CIM_RESP_OKAY : `CIM_RESP_SLVERR;
      if (st_r.aw_ok && st_r.w_en) begin
        case (st_r.aw_idx)
          `CIM_MODE_IDX: st_nxt.modes = st_r.w_data;
          `CIM_GATE_IDX: st_nxt.gates = st_r.w_data;
          default: st_nxt.flags = st_nxt.flags; // flags are read only
        endcase
      end
    end
    st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;

    // read channel
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = 32'h0;
      st_nxt.rresp = `CIM_RESP_OKAY;
      if (!is_mapped(s_axi_araddr)) begin
        st_nxt.rresp = `CIM_RESP_SLVERR;
      end else begin
        case (s_axi_araddr[9:2])
          `CIM_MODE_IDX: st_nxt.rdata[7:0] = st_r.modes;
          `CIM_GATE_IDX: st_nxt.rdata[7:0] = st_r.gates;
          default: st_nxt.rdata[7:0] = st_r.flags;
        endcase
      end
    end
    st_nxt.arready = !st_nxt.rvalid;

    if (!aresetn) begin
      st_nxt = '0;
      st_nxt.modes = `CIM_MODE_RST;
      st_nxt.gates = `CIM_GATE_RST;
      st_nxt.flags = `CIM_FLAG_RST;
    end
  end

  always_ff @(posedge aclk) begin
    st_r <= st_nxt;
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign irq = st_r.irq;
  assign clip_indicator_pin = st_r.clip;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  all_masked_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r.gates == 8'hff) |=> !st_r.irq)
    else $error("irq raised while every source is gated");

  level_drive_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r.modes == 8'haa) && (st_r.gates == 8'h00) && (st_r.sync2 != 8'h0)
    |=> st_r.irq)
    else $error("level mode source present but irq low");

  clip_live_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ##1 st_r.clip == ($past(st_r.sync2[1]) | $past(st_r.sync2[0])))
    else $error("clip pin does not follow overflow state");

  flags_nowrite_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_go && (st_r.aw_idx == `CIM_FLAG_IDX) && !rd_flags
    |=> ((~st_r.flags & $past(st_r.flags)) == 8'h0))
    else $error("write changed the flags register");

  edge_sets_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rise != 8'h0) |=> ((st_r.flags & $past(rise)) == $past(rise)))
    else $error("arrival edge did not set its flag");

  read_clears_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_flags && (rise == 8'h0)
    |=> (st_r.flags == 8'h0) && (st_r.rdata[7:0] == $past(st_r.flags))
        && st_r.rvalid)
    else $error("flags read did not return and clear the flags");

  read_drops_irq_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_flags && st_r.irq && (rise == 8'h0) && (fall == 8'h0)
    && (st_r.modes == 8'h00) |=> !st_r.irq)
    else $error("flags read left edge interrupt pending");

  edge_holds_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_r.irq && (st_r.modes == 8'h00) && !rd_flags && !wr_go
    |=> st_r.irq)
    else $error("edge interrupt dropped before flags read");

  fall_fires_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r.modes == 8'h55) && ((fall & ~st_r.gates) != 8'h0) && !wr_go
    |=> st_r.irq ##1 (st_r.irq || $past(rd_flags)))
    else $error("removal edge did not raise irq");

  rsvd_quiet_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r.modes == 8'hff) && (st_r.pend == 8'h0) && !wr_go
    |=> !st_r.irq)
    else $error("reserved mode raised irq");

  gate_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_go && st_r.aw_ok && st_r.w_en && (st_r.aw_idx == `CIM_GATE_IDX)
    |=> (st_r.gates == $past(st_r.w_data)) && st_r.bvalid)
    else $error("gates register not written");

  mute_group_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r.modes == 8'h08) && (st_r.gates == 8'h0f) && (rise[7:4] != 4'h0)
    |=> st_r.irq)
    else $error("mute group level mode did not drive irq");

  map_bits_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rise[7] |=> st_r.flags[7])
    else $error("dac b left mute flag not at bit 7");

  mute_flag_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rise[4] |=> st_r.flags[4])
    else $error("dac a right mute flag not set");

  port_flag_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rise[3] |=> st_r.flags[3])
    else $error("port b clock fault flag not set");

endmodule

// *** cim_pkg.sv ***
package cim_pkg;

  typedef enum logic [1:0] {
    CIM_RISE = 2'b00,
    CIM_FALL = 2'b01,
    CIM_LEVEL = 2'b10,
    CIM_RSVD = 2'b11
  } cim_mode_t;

  // bit order matches the flags and gates registers
  typedef struct packed {
    logic dac_b_left_mute;
    logic dac_b_right_mute;
    logic dac_a_left_mute;
    logic dac_a_right_mute;
    logic port_b_clock_fault;
    logic port_a_clock_fault;
    logic positive_clip;
    logic negative_clip;
  } cim_src_t;

  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    logic [7:0] flags;
    logic [7:0] pend;
    logic [7:0] gates;
    logic [7:0] modes;
    logic irq;
    logic clip;
    logic aw_have;
    logic [7:0] aw_idx;
    logic aw_ok;
    logic w_have;
    logic [7:0] w_data;
    logic w_en;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cim_state_t;

endpackage

// *** cim_src_model.sv ***
`timescale 1ns/100ps

// ---------------------------------------------------------------
// detector stand-in: levels reach the block a little after the edge
// ---------------------------------------------------------------
module cim_src_model (
  input wire cim_pkg::cim_src_t lvl, // requested detector levels
  output cim_pkg::cim_src_t src_cond // levels seen by the block
);
  import cim_pkg::*;
  // skewed off the clock so the sync flops see a truly async change
  // continuous so the idle level is present from 3 ns, well before reset ends
  assign #3 src_cond = lvl;
endmodule

// *** codec_interrupt_mask_status_test.sv ***
`timescale 1ns/100ps
`include "cim_consts.svh"
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, s); end end

module codec_interrupt_mask_status_test;
  import cim_pkg::*;
  localparam logic [31:0] MA = {22'h0, `CIM_MODE_IDX, 2'b00};
  localparam logic [31:0] GA = {22'h0, `CIM_GATE_IDX, 2'b00};
  localparam logic [31:0] FA = {22'h0, `CIM_FLAG_IDX, 2'b00};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, clip;
  logic [1:0] bresp, rresp;
  cim_src_t lvl = '0, src;
  logic [33:0] q[$];
  logic [33:0] e;
  logic [7:0] p;
  int bad_count = 0, checked = 0;

  always #12.5 aclk = ~aclk;

  cim_src_model pm (.lvl(lvl), .src_cond(src));

  cim_irq_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .src_cond(src), .irq(irq), .clip_indicator_pin(clip));

  // ---------------------------------------------------------------
  // answer monitor
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      e = q.pop_front();
      `CHK("read", e, {rresp, rdata})
    end
    if (bvalid && bready) begin
      e = q.pop_front();
      `CHK("write", e, {bresp, 32'h0})
    end
  end

  task automatic test_done();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 100) begin
      bad_count++;
      test_done();
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    int n;
    q.push_back({`CIM_RESP_OKAY, 32'h0});
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    tmo(n);
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] d,
                    input logic [1:0] r = `CIM_RESP_OKAY);
    int n;
    q.push_back({r, 24'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    tmo(n);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(33));
    wt(6);
    aresetn <= 1'b1;
    wt(2);
    rd(MA, 8'h00);
    rd(GA, 8'hff);
    rd(FA, 8'h00);
    rd(32'h64, 8'h00, `CIM_RESP_SLVERR);
    wr(FA, 8'hff);
    rd(FA, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      lvl <= cim_src_t'(8'h01 << i);
      wt(6);
      `CHK("irq", 1'b0, irq)
      `CHK("clip", (i < 2), clip)
      rd(FA, 8'h01 << i);
      rd(FA, 8'h00);
      lvl <= '0;
      wt(6);
    end
    $display("test flags done");
    wr(GA, 8'h00);
    wr(MA, 8'h2d); // port b rise, port a level, mute reserved, clip fall
    lvl <= cim_src_t'(8'h08);
    wt(6);
    `CHK("irq", 1'b1, irq)
    lvl <= '0;
    wt(6);
    `CHK("irq", 1'b1, irq)
    rd(FA, 8'h08);
    wt(3);
    `CHK("irq", 1'b0, irq)
    lvl <= cim_src_t'(8'h04);
    wt(6);
    rd(FA, 8'h04);
    wt(3);
    `CHK("irq", 1'b1, irq)
    lvl <= '0;
    wt(6);
    `CHK("irq", 1'b0, irq)
    lvl <= cim_src_t'(8'h02);
    wt(6);
    `CHK("irq", 1'b0, irq)
    rd(FA, 8'h02);
    lvl <= '0;
    wt(6);
    `CHK("irq", 1'b1, irq)
    rd(FA, 8'h00);
    wt(3);
    `CHK("irq", 1'b0, irq)
    lvl <= cim_src_t'(8'h80);
    wt(6);
    `CHK("irq", 1'b0, irq)
    rd(FA, 8'h80);
    lvl <= '0;
    wr(GA, 8'h08);
    lvl <= cim_src_t'(8'h08);
    wt(6);
    `CHK("irq", 1'b0, irq)
    rd(FA, 8'h08);
    lvl <= '0;
    wt(6);
    $display("test modes done");
    wr(GA, 8'h00);
    wr(MA, 8'h00); // every group on arrival
    lvl <= cim_src_t'(8'h10);
    wt(6);
    `CHK("irq", 1'b1, irq)
    lvl <= '0;
    wt(6);
    `CHK("irq", 1'b1, irq)
    rd(FA, 8'h10);
    wt(3);
    `CHK("irq", 1'b0, irq)
    wr(MA, 8'h55); // every group on removal
    lvl <= cim_src_t'(8'h01);
    wt(6);
    `CHK("irq", 1'b0, irq)
    rd(FA, 8'h01);
    lvl <= '0;
    wt(6);
    `CHK("irq", 1'b1, irq)
    rd(FA, 8'h00);
    wt(3);
    `CHK("irq", 1'b0, irq)
    wr(MA, 8'haa); // every group while present
    lvl <= cim_src_t'(8'h40);
    wt(6);
    `CHK("irq", 1'b1, irq)
    rd(FA, 8'h40);
    lvl <= '0;
    wt(6);
    `CHK("irq", 1'b0, irq)
    wr(MA, 8'hff); // reserved code everywhere
    lvl <= cim_src_t'(8'hff);
    wt(6);
    `CHK("irq", 1'b0, irq)
    rd(FA, 8'hff);
    lvl <= '0;
    wt(6);
    wr(GA, 8'h0f);
    wr(MA, 8'h08); // mute group while present, others on arrival
    lvl <= cim_src_t'(8'h2f);
    wt(6);
    `CHK("irq", 1'b1, irq)
    rd(FA, 8'h2f);
    lvl <= '0;
    wt(6);
    `CHK("irq", 1'b0, irq)
    $display("test groups done");
    wr(GA, 8'hff);
    repeat (4) begin
      p = 8'($urandom());
      lvl <= cim_src_t'(p);
      wt(6);
      `CHK("clip", |p[1:0], clip)
      rd(FA, p);
      lvl <= '0;
      wt(6);
      rd(FA, 8'h00);
    end
    $display("test random done");
    test_done();
  end
endmodule
